// [ipf_pkg.sv]
package ipf_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets (word aligned)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CORE_CONTROL = 8'h04;
    localparam logic [7:0] OFF_INT_CTRL_ONE = 8'h08;
    localparam logic [7:0] OFF_INT_CTRL_TWO = 8'h0C;
    localparam logic [7:0] OFF_FLAGS_ZERO = 8'h10;
    localparam logic [7:0] OFF_FLAGS_ONE = 8'h14;
    localparam logic [7:0] OFF_FLAGS_TWO = 8'h18;
    localparam logic [7:0] OFF_FLAGS_THREE = 8'h1C;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PRIO_LOW_LSB = 5;
    localparam int PRIO_HIGH_BIT = 3;
    localparam int PROG_VIS_BIT = 2;
    localparam int NEST_DIS_BIT = 15;
    localparam int ALT_VEC_BIT = 15;
    localparam int DISABLE_INSN_BIT = 14;
    localparam int MATH_TRAP_BIT = 4;
    localparam int ADDR_TRAP_BIT = 3;
    localparam int STACK_TRAP_BIT = 2;
    localparam int OSC_TRAP_BIT = 1;

    // Implemented bit masks
    localparam logic [15:0] MASK_FLAGS_ZERO = 16'h3FEF;
    localparam logic [15:0] MASK_FLAGS_ONE = 16'h381F;
    localparam logic [15:0] MASK_FLAGS_TWO = 16'h0020;
    localparam logic [15:0] MASK_FLAGS_THREE = 16'hC200;
    localparam logic [15:0] MASK_TRAPS = 16'h001E;
    localparam logic [15:0] MASK_EDGE = 16'h0007;
    localparam logic [15:0] RESET_ZERO = 16'h0000;

    // Highest priority level of the low field
    localparam logic [2:0] PRIO_LEVEL_MAX = 3'h7;

    typedef struct packed {
        logic math;
        logic addr;
        logic stack;
        logic osc;
    } ipf_trap_s;

    typedef struct packed {
        logic [15:0] zero;
        logic [15:0] one;
        logic [15:0] two;
        logic [15:0] three;
    } ipf_flags_s;

endpackage : ipf_pkg

// [ipf_flag_bank.sv]
// Sticky flag register with software write port; hardware set wins.
module ipf_flag_bank (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] mask_i,
    input wire logic [15:0] set_i,
    input wire logic wr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] flags_o
);

    logic [15:0] flags_q;
    logic [15:0] flags_d;

    always_comb begin
        flags_d = flags_q;
        if (wr_i) begin
            flags_d = wdata_i;
        end
        flags_d = (flags_d | set_i) & mask_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= ipf_pkg::RESET_ZERO;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;

endmodule : ipf_flag_bank

// [ipf_ctrl.sv]
module ipf_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cpu_prio_wr_i,
    input wire logic [3:0] cpu_prio_i,
    input wire ipf_pkg::ipf_trap_s trap_i,
    input wire ipf_pkg::ipf_flags_s irq_set_i,
    input wire logic disable_insn_active_i,
    output logic [3:0] cpu_priority_o,
    output logic user_irq_allowed_o,
    output logic preempt_allowed_o,
    output logic alt_vector_select_o,
    output logic [2:0] ext_edge_polarity_o,
    output logic program_space_visibility_o,
    output ipf_pkg::ipf_flags_s flags_o
);

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic req;
    logic wr_lo;
    logic [15:0] wdata;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    // One write strobe per register, decoded once
    logic wr_status;
    logic wr_core;
    logic wr_ctl_one;
    logic wr_ctl_two;
    logic [3:0] wr_flags;

    // Only the low 16-bit lanes carry data; sel[1:0] both required
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction : hit

    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_lo = req && wb_we_i && (wb_sel_i[1:0] == 2'h3);
    assign wdata = wb_dat_i[15:0];

    // Writes land at the taking edge; ack rises at that same edge
    assign wr_status = wr_lo && hit(wb_adr_i, ipf_pkg::OFF_STATUS);
    assign wr_core = wr_lo && hit(wb_adr_i, ipf_pkg::OFF_CORE_CONTROL);
    assign wr_ctl_one = wr_lo && hit(wb_adr_i, ipf_pkg::OFF_INT_CTRL_ONE);
    assign wr_ctl_two = wr_lo && hit(wb_adr_i, ipf_pkg::OFF_INT_CTRL_TWO);
    assign wr_flags = {4{wr_lo}} & {hit(wb_adr_i, ipf_pkg::OFF_FLAGS_THREE),
                                    hit(wb_adr_i, ipf_pkg::OFF_FLAGS_TWO),
                                    hit(wb_adr_i, ipf_pkg::OFF_FLAGS_ONE),
                                    hit(wb_adr_i, ipf_pkg::OFF_FLAGS_ZERO)};

    // ----------------------------------------------------------------
    // Priority and core control
    // ----------------------------------------------------------------
    logic [2:0] prio_low_q;
    logic prio_high_q;
    logic prog_vis_q;
    logic nest_dis_q;
    ipf_pkg::ipf_trap_s trap_q;
    logic alt_vec_q;
    logic [2:0] edge_q;
    logic disable_insn_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prio_low_q <= 3'h0;
        end else if (!nest_dis_q) begin
            if (cpu_prio_wr_i) begin
                prio_low_q <= cpu_prio_i[2:0];
            end else if (wr_status) begin
                prio_low_q <= wdata[ipf_pkg::PRIO_LOW_LSB +: 3];
            end
        end
    end

    // Core sets the high bit (trap entry); software may only clear it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prio_high_q <= 1'b0;
        end else if (cpu_prio_wr_i && cpu_prio_i[3]) begin
            prio_high_q <= 1'b1;
        end else if (cpu_prio_wr_i) begin
            prio_high_q <= 1'b0;
        end else if (wr_core && !wdata[ipf_pkg::PRIO_HIGH_BIT]) begin
            prio_high_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prog_vis_q <= 1'b0;
        end else if (wr_core) begin
            prog_vis_q <= wdata[ipf_pkg::PROG_VIS_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt control one: nesting disable and traps
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nest_dis_q <= 1'b0;
        end else if (wr_ctl_one) begin
            nest_dis_q <= wdata[ipf_pkg::NEST_DIS_BIT];
        end
    end

    // A trap in the same cycle as a clearing write still lands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trap_q <= '0;
        end else begin
            if (wr_ctl_one) begin
                trap_q.math <= wdata[ipf_pkg::MATH_TRAP_BIT] | trap_i.math;
                trap_q.addr <= wdata[ipf_pkg::ADDR_TRAP_BIT] | trap_i.addr;
                trap_q.stack <= wdata[ipf_pkg::STACK_TRAP_BIT] | trap_i.stack;
                trap_q.osc <= wdata[ipf_pkg::OSC_TRAP_BIT] | trap_i.osc;
            end else begin
                trap_q <= trap_q | trap_i;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt control two: vector table and edge polarity
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alt_vec_q <= 1'b0;
            edge_q <= 3'h0;
        end else if (wr_ctl_two) begin
            alt_vec_q <= wdata[ipf_pkg::ALT_VEC_BIT];
            edge_q <= wdata[2:0];
        end
    end

    // Status of the disable-interrupts instruction, read only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disable_insn_q <= 1'b0;
        end else begin
            disable_insn_q <= disable_insn_active_i;
        end
    end

    // ----------------------------------------------------------------
    // Flag registers
    // ----------------------------------------------------------------
    ipf_pkg::ipf_flags_s flags;

    ipf_flag_bank u_flags_zero (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mask_i(ipf_pkg::MASK_FLAGS_ZERO),
        .set_i(irq_set_i.zero),
        .wr_i(wr_flags[0]),
        .wdata_i(wdata),
        .flags_o(flags.zero)
    );

    ipf_flag_bank u_flags_one (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mask_i(ipf_pkg::MASK_FLAGS_ONE),
        .set_i(irq_set_i.one),
        .wr_i(wr_flags[1]),
        .wdata_i(wdata),
        .flags_o(flags.one)
    );

    ipf_flag_bank u_flags_two (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mask_i(ipf_pkg::MASK_FLAGS_TWO),
        .set_i(irq_set_i.two),
        .wr_i(wr_flags[2]),
        .wdata_i(wdata),
        .flags_o(flags.two)
    );

    ipf_flag_bank u_flags_three (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mask_i(ipf_pkg::MASK_FLAGS_THREE),
        .set_i(irq_set_i.three),
        .wr_i(wr_flags[3]),
        .wdata_i(wdata),
        .flags_o(flags.three)
    );

    // ----------------------------------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (wb_adr_i)
            ipf_pkg::OFF_STATUS: rdata_d[ipf_pkg::PRIO_LOW_LSB +: 3] = prio_low_q;
            ipf_pkg::OFF_CORE_CONTROL: begin
                rdata_d[ipf_pkg::PRIO_HIGH_BIT] = prio_high_q;
                rdata_d[ipf_pkg::PROG_VIS_BIT] = prog_vis_q;
            end
            ipf_pkg::OFF_INT_CTRL_ONE: begin
                rdata_d[ipf_pkg::NEST_DIS_BIT] = nest_dis_q;
                rdata_d[ipf_pkg::MATH_TRAP_BIT] = trap_q.math;
                rdata_d[ipf_pkg::ADDR_TRAP_BIT] = trap_q.addr;
                rdata_d[ipf_pkg::STACK_TRAP_BIT] = trap_q.stack;
                rdata_d[ipf_pkg::OSC_TRAP_BIT] = trap_q.osc;
            end
            ipf_pkg::OFF_INT_CTRL_TWO: begin
                rdata_d[ipf_pkg::ALT_VEC_BIT] = alt_vec_q;
                rdata_d[ipf_pkg::DISABLE_INSN_BIT] = disable_insn_q;
                rdata_d[2:0] = edge_q;
            end
            ipf_pkg::OFF_FLAGS_ZERO: rdata_d[15:0] = flags.zero;
            ipf_pkg::OFF_FLAGS_ONE: rdata_d[15:0] = flags.one;
            ipf_pkg::OFF_FLAGS_TWO: rdata_d[15:0] = flags.two;
            ipf_pkg::OFF_FLAGS_THREE: rdata_d[15:0] = flags.three;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // One wait-free ack per request; unmapped addresses ack with zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            rdata_q <= req ? rdata_d : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // Priority view for the core; one cycle behind the registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_priority_o <= 4'h0;
            user_irq_allowed_o <= 1'b0;
        end else begin
            cpu_priority_o <= {prio_high_q, prio_low_q};
            // Level 7 or high bit set masks every user source
            user_irq_allowed_o <= !prio_high_q
                                  && (prio_low_q != ipf_pkg::PRIO_LEVEL_MAX);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            preempt_allowed_o <= 1'b0;
            alt_vector_select_o <= 1'b0;
            ext_edge_polarity_o <= 3'h0;
            program_space_visibility_o <= 1'b0;
        end else begin
            preempt_allowed_o <= !nest_dis_q;
            alt_vector_select_o <= alt_vec_q;
            ext_edge_polarity_o <= edge_q;
            program_space_visibility_o <= prog_vis_q;
        end
    end

    // Flag copy for the vector logic, registered like every output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_o <= '0;
        end else begin
            flags_o <= flags;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

endmodule : ipf_ctrl

// [ipf_src_model.sv]
module ipf_src_model (
    input wire logic fire_i,
    input wire logic [63:0] irq_pat_i,
    input wire logic [3:0] trap_pat_i,
    output ipf_pkg::ipf_flags_s irq_set_o,
    output ipf_pkg::ipf_trap_s trap_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sources only ever set; clearing is left to software
    always_comb begin
        irq_set_o = fire_i ? irq_pat_i : 64'h0;
        trap_o = fire_i ? trap_pat_i : 4'h0;
    end
endmodule : ipf_src_model

// [ipf_ctrl_checker.sv]
module ipf_ctrl_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic cpu_prio_wr_i,
    input wire logic [3:0] cpu_prio_i,
    input wire ipf_pkg::ipf_flags_s irq_set_i,
    input wire logic [3:0] cpu_priority_o,
    input wire logic user_irq_allowed_o,
    input wire ipf_pkg::ipf_flags_s flags_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] FMASK = {ipf_pkg::MASK_FLAGS_ZERO, ipf_pkg::MASK_FLAGS_ONE,
        ipf_pkg::MASK_FLAGS_TWO, ipf_pkg::MASK_FLAGS_THREE};
    logic wr_f0;
    assign wr_f0 = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_adr_i == ipf_pkg::OFF_FLAGS_ZERO;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_ONE:
    assert property (s_take |=> s_ack) else $error("ack not a pulse after request");
    AST_DAT_IDLE:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    AST_DAT_HIGH:
    assert property (wb_dat_o[31:16] == 16'h0) else $error("upper read half not zero");
    AST_USER_ALLOW:
    assert property (!$past(rst_i, 2) && !$past(rst_i) |-> user_irq_allowed_o
        == (!cpu_priority_o[3] && cpu_priority_o[2:0] != 3'h7)) else $error("user allow bad");
    AST_HIGH_SET:
    assert property ($rose(cpu_priority_o[3]) |-> $past(cpu_prio_wr_i, 2)
        && $past(cpu_prio_i[3], 2)) else $error("high priority bit set without core");
    AST_FLAG_MASK:
    assert property ((flags_o & ~FMASK) == 64'h0) else $error("unimplemented flag set");
    AST_FLAG_SET0:
    assert property (irq_set_i.zero[0] |-> ##2 flags_o.zero[0]) else $error("flag not set");
    AST_FLAG_SET3:
    assert property (irq_set_i.three[9] |-> ##2 flags_o.three[9]) else $error("flag not set");
    AST_FLAG_CLR:
    assert property ($fell(flags_o.zero[0]) && !$past(rst_i) |-> $past(wr_f0, 2))
        else $error("flag cleared without write");
endmodule : ipf_ctrl_checker

bind ipf_ctrl ipf_ctrl_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cpu_prio_wr_i(cpu_prio_wr_i), .cpu_prio_i(cpu_prio_i),
    .irq_set_i(irq_set_i), .cpu_priority_o(cpu_priority_o),
    .user_irq_allowed_o(user_irq_allowed_o), .flags_o(flags_o));

// [ipf_ctrl_test.sv]
module ipf_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pw = 1'b0, fire = 1'b0, dia = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, pv = 4'h0, tpat = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [63:0] ipat = 64'h0;
    logic [31:0] rdat, r;
    logic ack, ua, pa, alt, pvis;
    logic [3:0] prio;
    logic [2:0] edg;
    ipf_pkg::ipf_flags_s set, flg;
    ipf_pkg::ipf_trap_s trp;
    logic [15:0] fixed [4] = '{16'h00E0, 16'h0004, 16'h801E, 16'h8007};
    logic [3:0] ptab [3] = '{4'h3, 4'h7, 4'h8};
    int fail_count = 0, n_checks = 0, cyc_cnt = 0, seed = 96755, i, k;

    ipf_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cpu_prio_wr_i(pw), .cpu_prio_i(pv), .trap_i(trp), .irq_set_i(set),
        .disable_insn_active_i(dia), .cpu_priority_o(prio), .user_irq_allowed_o(ua),
        .preempt_allowed_o(pa), .alt_vector_select_o(alt), .ext_edge_polarity_o(edg),
        .program_space_visibility_o(pvis), .flags_o(flg));
    ipf_src_model src (.fire_i(fire), .irq_pat_i(ipat), .trap_pat_i(tpat), .irq_set_o(set),
        .trap_o(trp));

    initial begin
        forever #2 clk_i = ~clk_i;
    end

    function automatic logic [15:0] fmask(input int n);
        case (n)
            0: return ipf_pkg::MASK_FLAGS_ZERO;
            1: return ipf_pkg::MASK_FLAGS_ONE;
            2: return ipf_pkg::MASK_FLAGS_TWO;
            default: return ipf_pkg::MASK_FLAGS_THREE;
        endcase
    endfunction : fmask

    function automatic logic uexp(input logic [3:0] p);
        return !p[3] && p[2:0] != 3'h7;
    endfunction : uexp

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t read %h want %h", $time, got, exp);
        end
    endtask : chk_reg

    // Outputs trail state by one edge; sample mid-cycle once they settle
    task automatic chk_pin(input logic ctl, input logic [7:0] exp);
        logic [7:0] got;
        @(posedge clk_i);
        @(negedge clk_i);
        got = ctl ? {2'h0, alt, edg, pvis, pa} : {3'h0, ua, prio};
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t pins %h want %h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic chk_flags(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t flags %h want %h", $time, got, exp);
        end
    endtask : chk_flags

    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
        input logic [3:0] s, input logic f);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= {16'h0, d};
        fire <= f;
        do begin
            @(posedge clk_i);
            fire <= 1'b0;
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        wb(1'b0, a, 16'h0, 4'hF, 1'b0);
        chk_reg(r, {16'h0, e});
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb(1'b1, a, d, 4'hF, 1'b0);
    endtask : wr

    task automatic core(input logic [3:0] v);
        @(posedge clk_i);
        pw <= 1'b1;
        pv <= v;
        @(posedge clk_i);
        pw <= 1'b0;
    endtask : core

    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 9000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (i = 0; i < 9; i++)
            rd(8'(i * 4), 16'h0);
        $display("test reset done");
        for (i = 0; i < 8; i++)
            wr(8'(i * 4), 16'hFFFF);
        for (i = 0; i < 8; i++)
            rd(8'(i * 4), i < 4 ? fixed[i] : fmask(i - 4));
        chk_pin(1'b1, 8'h3E);
        wr(8'h00, 16'h0);
        rd(8'h00, 16'h00E0);
        core(4'h2);
        chk_pin(1'b0, 8'h07);
        $display("test nesting done");
        wr(8'h08, 16'h0);
        wb(1'b1, 8'h0C, 16'h0, 4'h1, 1'b0);
        dia <= 1'b1;
        rd(8'h0C, 16'hC007);
        for (i = 0; i < 8; i++) begin
            wr(8'h0C, 16'(i));
            chk_pin(1'b1, {2'h0, 1'b0, 3'(i), 2'h3});
        end
        for (i = 0; i < 3; i++) begin
            core(ptab[i]);
            chk_pin(1'b0, {3'h0, uexp(ptab[i]), ptab[i]});
        end
        rd(8'h04, 16'h000C);
        wr(8'h04, 16'h0);
        chk_pin(1'b0, 8'h10);
        $display("test priority done");
        for (i = 0; i < 16; i++) begin
            // Clear traps and all four flag words before each burst
            for (k = 0; k < 5; k++)
                wr(8'(k == 0 ? 8 : 12 + 4 * k), 16'h0);
            ipat <= {$random(seed), $random(seed)};
            tpat <= 4'($random(seed));
            wb(1'b1, 8'h20, 16'hFFFF, 4'hF, 1'b1);
            for (k = 0; k < 4; k++)
                rd(8'(16 + 4 * k), ipat[16 * (3 - k) +: 16] & fmask(k));
            chk_flags(flg, ipat & {fmask(0), fmask(1), fmask(2), fmask(3)});
            rd(8'h08, {11'h0, tpat, 1'b0});
        end
        ipat <= 64'h0001_0000_0000_0000;
        wb(1'b1, 8'h10, 16'h0, 4'hF, 1'b1);
        rd(8'h10, 16'h0001);
        $display("test flags done");
        test_done();
    end
endmodule : ipf_ctrl_test
